// ### design/bbd_core.sv
// Purpose: execute branch, bit set/clear, control and far jump groups
// Assumes: program bytes one cycle after a read strobe, data bytes in the strobe cycle
// Notes:   one cycle is one clock of mclk_in
// Behaviour
// - four short branches on carry or zero, two cycles, flags kept
// - short displacement is 5-bit signed, target -15 to +16
// - bit-test branch on bit clear or set, three bytes, five cycles
// - bit-test copies tested bit into carry, zero kept
// - bit-test displacement is 8-bit signed, target -126 to +129
// - set or clear any data bit, two bytes, four cycles, no flags
// - no-op, return, interrupt return, stop, wait: two cycles each
// - with watchdog option, stop acts as wait
// - absolute jump and call with 12-bit target, four cycles
// - bit-test bytes are opcode, data address, displacement
// - bit set/clear takes bit from opcode, address from next byte
`include "bbd_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module bbd_core
  import bbd_pkg::*;
#(
  parameter logic [11:0] RST_PC    = 12'h000,
  parameter int          STK_DEPTH = 6
) (
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  // program memory
  output logic [11:0]      pm_addr_out,
  output logic             pm_rd_out,
  input  wire logic [7:0]  pm_data_in,
  // data space memory
  output logic [7:0]       dm_addr_out,
  output logic             dm_rd_out,
  output logic             dm_wr_out,
  output logic [7:0]       dm_wdata_out,
  input  wire logic [7:0]  dm_rdata_in,
  // flags from other instruction groups
  input  wire logic        flag_ld_in,
  input  wire logic        flag_z_in,
  input  wire logic        flag_c_in,
  // option and wake
  input  wire logic        wdog_opt_in,
  input  wire logic        wake_in,
  // status
  output logic             z_out,
  output logic             c_out,
  output logic             stop_out,
  output logic             wait_out,
  output logic             illegal_out
);

  localparam int             SPW     = $clog2(STK_DEPTH);
  localparam logic [SPW-1:0] SP_LAST = SPW'(STK_DEPTH - 1);

  // =====================================================================
  // state
  bbd_state_type     state_r;
  bbd_state_type     state_nxt;
  logic [2:0]        cyc_r;
  logic [2:0]        cyc_nxt;
  logic [7:0]        op_r;
  logic [7:0]        arg_r;
  logic [11:0]       pc_r;
  logic [11:0]       pc_nxt;
  logic              z_r;
  logic              c_r;
  logic              z_nxt;
  logic              c_nxt;
  logic [13:0]       stk_r [STK_DEPTH];
  logic [SPW-1:0]    sp_r;
  logic [11:0]       pm_addr_r;
  logic [11:0]       pm_addr_nxt;
  logic              pm_rd_r;
  logic              pm_rd_nxt;
  logic [7:0]        dm_addr_r;
  logic              dm_rd_r;
  logic              dm_wr_r;
  logic [7:0]        dm_wdata_r;
  logic              stop_r;
  logic              wait_r;
  logic              illegal_r;

  // =====================================================================
  // decode; opcode is live on the bus in cycle 1
  wire              run    = (state_r == BBD_RUN);
  wire              cyc1   = run && (cyc_r == 3'h1);
  wire              cyc2   = run && (cyc_r == 3'h2);
  wire              cyc3   = run && (cyc_r == 3'h3);
  wire [7:0]        op_w   = cyc1 ? pm_data_in : op_r;
  wire [2:0]        cls    = op_w[2:0];
  wire              is_brz = (cls == `BBD_CLS_BRZC) || (cls == `BBD_CLS_BRZS);
  wire              is_brc = (cls == `BBD_CLS_BRCC) || (cls == `BBD_CLS_BRCS);
  wire              is_shr = is_brz || is_brc;
  wire              is_far = (cls == `BBD_CLS_FAR);
  wire              is_cal = is_far && !op_w[`BBD_SUB_BIT];
  wire              is_bit = (cls == `BBD_CLS_BIT);
  wire              is_bts = is_bit && !op_w[`BBD_SUB_BIT];
  wire              is_bmd = is_bit && op_w[`BBD_SUB_BIT];
  wire              pol    = op_w[`BBD_POL_BIT];
  wire [2:0]        bidx   = {op_w[5], op_w[6], op_w[7]};
  wire              is_nop = (op_w == `BBD_OP_NOP);
  wire              is_ret = (op_w == `BBD_OP_RET);
  wire              is_rti = (op_w == `BBD_OP_INTERRUPT_RETURN);
  wire              is_stp = (op_w == `BBD_OP_STOP);
  wire              is_wai = (op_w == `BBD_OP_WAIT);
  wire              is_ctl = is_nop || is_ret || is_rti || is_stp || is_wai;
  wire              is_ill = !(is_shr || is_far || is_bit || is_ctl);

  // short condition: zero group uses bit 2 as polarity, carry likewise
  wire              cond   = is_brz ? (z_r == op_w[2]) : (c_r == op_w[2]);

  // =====================================================================
  // instruction length in cycles and last cycle detect
  wire [2:0]        ncyc   = is_bts ? `BBD_CYC_BTST :
                             is_bmd ? `BBD_CYC_BMOD :
                             is_far ? `BBD_CYC_FAR  :
                             is_shr ? `BBD_CYC_SHORT :
                             `BBD_CYC_CTL;
  wire              last   = run && (cyc_r == ncyc - 3'h1);

  // =====================================================================
  // branch targets
  wire [11:0]       e_sx   = {{7{op_w[7]}}, op_w[7:3]};
  wire [11:0]       ee_sx  = {{4{pm_data_in[7]}}, pm_data_in};
  wire [11:0]       pc_p1  = pc_r + `BBD_STEP1;
  wire [11:0]       pc_p2  = pc_r + `BBD_STEP2;
  wire [11:0]       t_shr  = pc_p1 + e_sx;
  wire [11:0]       t_bts  = pc_p2 + ee_sx;
  wire              tbit   = dm_rdata_in[bidx];
  // low target byte is on the bus in the jump's last cycle
  wire [7:0]        arg_w  = cyc3 ? pm_data_in : arg_r;
  wire [11:0]       t_far  = {op_w[7:4], arg_w};
  // stack pointer steps wrap at the stack depth, never past the array
  wire [SPW-1:0]    sp_one = {{(SPW-1){1'b0}}, 1'b1};
  wire [SPW-1:0]    sp_up  = (sp_r == SP_LAST) ? '0 : (sp_r + sp_one);
  wire [SPW-1:0]    sp_dn  = (sp_r == '0) ? SP_LAST : (sp_r - sp_one);
  wire [13:0]       top    = stk_r[sp_dn];
  wire              halt_go = cyc1 && (is_stp || is_wai);
  wire              go_stop = is_stp && !wdog_opt_in;

  // modified data byte for set/clear
  wire [7:0]        bmask  = 8'h01 << bidx;
  wire [7:0]        bmod   = pol ? (dm_rdata_in | bmask) : (dm_rdata_in & ~bmask);

  // =====================================================================
  // next program counter at the last cycle
  always_comb begin
    pc_nxt = pc_p1;
    if (is_shr) begin
      pc_nxt = cond ? t_shr : pc_p1;
    end else if (is_bts) begin
      pc_nxt = (tbit == pol) ? t_bts : (pc_r + `BBD_STEP3);
    end else if (is_bmd) begin
      pc_nxt = pc_p2;
    end else if (is_far) begin
      pc_nxt = t_far;
    end else if (is_ret || is_rti) begin
      pc_nxt = top[11:0];
    end
  end

  // =====================================================================
  // flags: instruction writes win over the outside load
  always_comb begin
    z_nxt = flag_ld_in ? flag_z_in : z_r;
    c_nxt = flag_ld_in ? flag_c_in : c_r;
    if (last && is_bts) begin
      c_nxt = tbit;
    end else if (last && is_rti) begin
      z_nxt = top[13];
      c_nxt = top[12];
    end
  end

  // =====================================================================
  // program memory requests
  always_comb begin
    pm_rd_nxt   = 1'b0;
    pm_addr_nxt = pm_addr_r;
    state_nxt   = state_r;
    cyc_nxt     = run ? (cyc_r + 3'h1) : 3'h0;
    if (state_r == BBD_START) begin
      pm_rd_nxt   = 1'b1;
      pm_addr_nxt = pc_r;
      state_nxt   = BBD_RUN;
    end else if (state_r == BBD_HALT) begin
      if (wake_in) begin
        pm_rd_nxt   = 1'b1;
        pm_addr_nxt = pc_r;
        state_nxt   = BBD_RUN;
      end
    end else if (halt_go) begin
      state_nxt = BBD_HALT;
      cyc_nxt   = 3'h0;
    end else if (last) begin
      pm_rd_nxt   = 1'b1;
      pm_addr_nxt = pc_nxt;
      cyc_nxt     = 3'h0;
    end else if (cyc1 && (is_far || is_bit)) begin
      pm_rd_nxt   = 1'b1;
      pm_addr_nxt = pc_p1;
    end else if (cyc2 && is_bts) begin
      pm_rd_nxt   = 1'b1;
      pm_addr_nxt = pc_p2;
    end
  end

  // =====================================================================
  // sequencer, pc and opcode latch
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_r <= BBD_START;
      cyc_r   <= 3'h0;
      pc_r    <= RST_PC;
      op_r    <= 8'h00;
      arg_r   <= 8'h00;
    end else begin
      state_r <= state_nxt;
      cyc_r   <= cyc_nxt;
      if (cyc1) op_r <= pm_data_in;
      if (cyc3) arg_r <= pm_data_in;
      if (halt_go) pc_r <= pc_p1;
      else if (last) pc_r <= pc_nxt;
    end
  end

  // =====================================================================
  // return stack with saved flags
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      sp_r <= '0;
    end else if (last && is_cal) begin
      stk_r[sp_r] <= {z_r, c_r, pc_p2};
      sp_r        <= sp_up;
    end else if (last && (is_ret || is_rti)) begin
      sp_r <= sp_dn;
    end
  end

  // =====================================================================
  // data space accesses
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      dm_addr_r  <= 8'h00;
      dm_rd_r    <= 1'b0;
      dm_wr_r    <= 1'b0;
      dm_wdata_r <= 8'h00;
    end else begin
      // data address is on the bus in cycle 3; read in cycle 4
      dm_rd_r <= cyc3 && is_bit;
      // set/clear write trails into the next opcode's cycle 1, one cycle after its fetch cycle
      dm_wr_r <= dm_rd_r && is_bmd;
      if (cyc3 && is_bit) dm_addr_r <= pm_data_in;
      if (dm_rd_r) dm_wdata_r <= bmod;
    end
  end

  // =====================================================================
  // flags, memory strobes and status
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      z_r       <= 1'b0;
      c_r       <= 1'b0;
      pm_addr_r <= 12'h000;
      pm_rd_r   <= 1'b0;
      stop_r    <= 1'b0;
      wait_r    <= 1'b0;
      illegal_r <= 1'b0;
    end else begin
      z_r       <= z_nxt;
      c_r       <= c_nxt;
      pm_addr_r <= pm_addr_nxt;
      pm_rd_r   <= pm_rd_nxt;
      illegal_r <= cyc1 && is_ill;
      if (halt_go) begin
        stop_r <= go_stop;
        wait_r <= !go_stop;
      end else if (state_r == BBD_HALT && wake_in) begin
        stop_r <= 1'b0;
        wait_r <= 1'b0;
      end
    end
  end

  // output wiring straight from flops
  assign pm_addr_out  = pm_addr_r;
  assign pm_rd_out    = pm_rd_r;
  assign dm_addr_out  = dm_addr_r;
  assign dm_rd_out    = dm_rd_r;
  assign dm_wr_out    = dm_wr_r;
  assign dm_wdata_out = dm_wdata_r;
  assign z_out        = z_r;
  assign c_out        = c_r;
  assign stop_out     = stop_r;
  assign wait_out     = wait_r;
  assign illegal_out  = illegal_r;

endmodule : bbd_core

`default_nettype wire

// ### pkg/bbd_defs.svh
// Purpose: constants for the branch, bit and control decoder
// Assumes: 8-bit opcodes, 12-bit program counter
// Notes:   included by the decoder core only
`ifndef BBD_DEFS_SVH
`define BBD_DEFS_SVH

// =====================================================================
// opcode class field, bits 2..0
`define BBD_CLS_BRZC   3'h0
`define BBD_CLS_FAR    3'h1
`define BBD_CLS_BRCC   3'h2
`define BBD_CLS_BIT    3'h3
`define BBD_CLS_BRZS   3'h4
`define BBD_CLS_CTLA   3'h5
`define BBD_CLS_BRCS   3'h6
`define BBD_CLS_CTLB   3'h7
// field positions
`define BBD_SUB_BIT    3
`define BBD_POL_BIT    4

// =====================================================================
// control opcodes
`define BBD_OP_NOP     8'h2D
`define BBD_OP_RET     8'hCD
`define BBD_OP_INTERRUPT_RETURN    8'h4D
`define BBD_OP_STOP    8'h6D
`define BBD_OP_WAIT    8'hED

// =====================================================================
// cycles per instruction group
`define BBD_CYC_SHORT  3'h2
`define BBD_CYC_BTST   3'h5
`define BBD_CYC_BMOD   3'h4
`define BBD_CYC_FAR    3'h4
`define BBD_CYC_CTL    3'h2

// =====================================================================
// program counter steps
`define BBD_STEP1      12'h001
`define BBD_STEP2      12'h002
`define BBD_STEP3      12'h003

`endif

// ### pkg/bbd_pkg.sv
// Purpose: types for the branch, bit and control decoder
// Assumes: nothing
// Notes:   sequencer states are gray coded
package bbd_pkg;

  // =====================================================================
  // sequencer states
  typedef enum logic [1:0] {
    BBD_START = 2'h0,
    BBD_RUN   = 2'h1,
    BBD_HALT  = 2'h3
  } bbd_state_type;

endpackage : bbd_pkg

// ### verification/bbd_core_assertions.sv
// Purpose: port checks for bbd_core
// Assumes: one clock, synchronous reset
// Notes:   bound to every bbd_core
`timescale 1ns/100ps
`default_nettype none
// ==========
// checker
module bbd_core_assertions (
  // watched ports
  input wire logic       mclk_in,
  input wire logic       rst_in,
  input wire logic       pm_rd_out,
  input wire logic [7:0] pm_data_in,
  input wire logic       dm_rd_out,
  input wire logic       dm_wr_out,
  input wire logic [7:0] dm_wdata_out,
  input wire logic [7:0] dm_rdata_in,
  input wire logic       flag_ld_in,
  input wire logic       wdog_opt_in,
  input wire logic       wake_in,
  input wire logic       z_out,
  input wire logic       c_out,
  input wire logic       stop_out,
  input wire logic       wait_out,
  input wire logic       illegal_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  wire logic halted = stop_out || wait_out;
  // fetch resumes soon after wake
  sequence resume_s;
    ##[1:3] pm_rd_out;
  endsequence
  halt_excl_a: assert property (!(stop_out && wait_out))
    else $error("stop and wait both high");
  stop_opt_a: assert property ($rose(stop_out) |-> !wdog_opt_in)
    else $error("stop under watchdog option");
  halt_idle_a: assert property (halted |-> !pm_rd_out && !dm_wr_out)
    else $error("activity while halted");
  wake_fetch_a: assert property (halted && wake_in |-> resume_s)
    else $error("no fetch after wake");
  write_bit_a: assert property (dm_wr_out |-> $countones(dm_wdata_out ^ dm_rdata_in) <= 1)
    else $error("write alters several bits");
  z_keep_a: assert property ($changed(z_out) |->
    $past(flag_ld_in) || $past(pm_data_in) == 8'h4D)
    else $error("zero flag changed");
  c_keep_a: assert property ($changed(c_out) |->
    $past(flag_ld_in) || $past(pm_data_in) == 8'h4D || $past(dm_rd_out))
    else $error("carry flag changed");
  ill_pulse_a: assert property (illegal_out |=> !illegal_out)
    else $error("illegal pulse too long");
endmodule : bbd_core_assertions
bind bbd_core bbd_core_assertions u_chk (.mclk_in, .rst_in, .pm_rd_out, .pm_data_in,
  .dm_rd_out, .dm_wr_out, .dm_wdata_out, .dm_rdata_in, .flag_ld_in, .wdog_opt_in,
  .wake_in, .z_out, .c_out, .stop_out, .wait_out, .illegal_out);
`default_nettype wire

// ### verification/bbd_mem_model.sv
// Purpose: program and data memory beside bbd_core
// Assumes: byte ready one cycle after read strobe
// Notes:   data read is combinational from the held address
`timescale 1ns/100ps
`default_nettype none
// ==========
// memory model
module bbd_mem_model (
  // program side
  input  wire logic        mclk_in,
  input  wire logic [11:0] pm_addr_in,
  input  wire logic        pm_rd_in,
  output logic [7:0]       pm_data_out,
  // data side
  input  wire logic [7:0]  dm_addr_in,
  input  wire logic        dm_wr_in,
  input  wire logic [7:0]  dm_wdata_in,
  output logic [7:0]       dm_rdata_out
);
  logic [7:0] prog [4096];
  logic [7:0] dat [256];
  // fetched byte, else a pattern that keeps changing
  always @(posedge mclk_in) begin
    pm_data_out <= pm_rd_in ? prog[pm_addr_in] : ~pm_data_out;
    if (dm_wr_in)
      dat[dm_addr_in] <= dm_wdata_in;
  end
  assign dm_rdata_out = dat[dm_addr_in];
endmodule : bbd_mem_model
`default_nettype wire

// ### verification/tb_branch_bit_control_decoder.sv
// Purpose: self-checking bench for bbd_core
// Assumes: memory model gives bytes as handed over
// Notes:   each instruction is written at its own fetch cycle
`timescale 1ns/100ps
`default_nettype none
// ==========
// bench top
module tb_branch_bit_control_decoder;
  logic        mclk_in = 1'b0, rst_in = 1'b1, wdog_opt_in = 1'b0, wake_in = 1'b0;
  logic        flag_ld_in = 1'b0, flag_z_in = 1'b0, flag_c_in = 1'b0, pend = 1'b0, saw;
  logic        pm_rd_out, dm_rd_out, dm_wr_out, z_out, c_out, stop_out, wait_out, illegal_out;
  logic [11:0] pm_addr_out, pc;
  logic [7:0]  pm_data_in, dm_addr_out, dm_wdata_out, dm_rdata_in, prr, pv;
  logic [13:0] stk [$];
  int          fails = 0, cmp_count = 0, seed;
  // clock and instances
  always #50 mclk_in = ~mclk_in;
  bbd_core i_dut (.mclk_in, .rst_in, .pm_addr_out, .pm_rd_out, .pm_data_in, .dm_addr_out,
    .dm_rd_out, .dm_wr_out, .dm_wdata_out, .dm_rdata_in, .flag_ld_in, .flag_z_in,
    .flag_c_in, .wdog_opt_in, .wake_in, .z_out, .c_out, .stop_out, .wait_out, .illegal_out);
  bbd_mem_model i_mem (.mclk_in, .pm_addr_in(pm_addr_out), .pm_rd_in(pm_rd_out),
    .pm_data_out(pm_data_in), .dm_addr_in(dm_addr_out), .dm_wr_in(dm_wr_out),
    .dm_wdata_in(dm_wdata_out), .dm_rdata_out(dm_rdata_in));
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] s);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  // the five assigned control opcodes; all else in their classes is illegal
  function automatic logic ctl_known(input logic [7:0] op);
    return op inside {8'h2D, 8'hCD, 8'h4D, 8'h6D, 8'hED};
  endfunction : ctl_known
  task automatic wait_rd();
    for (int i = 0; i < 20 && pm_rd_out !== 1'b1; i++)
      @(negedge mclk_in);
  endtask : wait_rd
  // one instruction from its fetch cycle to the next fetch
  task automatic run(input logic [7:0] op, b1, b2, input int n, input logic [11:0] nxt,
                     input logic [1:0] ef);
    chk("strobe", 12'h001, {11'h000, pm_rd_out});
    chk("pc", pc, pm_addr_out);
    i_mem.prog[pc] = op;
    i_mem.prog[pc + 12'h001] = b1;
    i_mem.prog[pc + 12'h002] = b2;
    flag_ld_in = 1'b1;
    saw = 1'b0;
    for (int k = 0; k < n; k++) begin
      @(negedge mclk_in);
      flag_ld_in = 1'b0;
      saw |= illegal_out;
    end
    chk("flags", {10'h000, ef}, {10'h000, z_out, c_out});
    if (pend)
      chk("data", {4'h0, pv}, {4'h0, i_mem.dat[prr]});
    pend = 1'b0;
    pc = nxt;
  endtask : run
  task automatic br(input logic [2:0] cls, input logic [4:0] e);
    logic t;
    t = cls[1] ? flag_c_in == cls[2] : flag_z_in == cls[2];
    run({e, cls}, 8'h00, 8'h00, 2, t ? pc + 12'h001 + {{7{e[4]}}, e} : pc + 12'h001,
        {flag_z_in, flag_c_in});
  endtask : br
  task automatic bt(input logic [2:0] b, input logic p, input logic [7:0] ee, v);
    logic [7:0] rr;
    rr = {1'b1, 7'($urandom)};
    i_mem.dat[rr] = v;
    run({b[0], b[1], b[2], p, 4'h3}, rr, ee, 5,
        v[b] == p ? pc + 12'h002 + {{4{ee[7]}}, ee} : pc + 12'h003, {flag_z_in, v[b]});
  endtask : bt
  task automatic bm(input logic [2:0] b, input logic p);
    logic [7:0] rr, v;
    rr = {1'b0, 7'($urandom)};
    if (pend && rr == prr)
      rr ^= 8'h01;
    v = 8'($urandom);
    i_mem.dat[rr] = v;
    run({b[0], b[1], b[2], p, 4'hB}, rr, 8'h00, 4, pc + 12'h002, {flag_z_in, flag_c_in});
    v[b] = p;
    prr = rr;
    pv = v;
    pend = 1'b1;
  endtask : bm
  task automatic jc(input logic j, input logic [11:0] t);
    if (!j)
      stk.push_back({flag_z_in, flag_c_in, pc + 12'h002});
    run({t[11:8], j, 3'h1}, t[7:0], 8'h00, 4, t, {flag_z_in, flag_c_in});
  endtask : jc
  task automatic ctl(input logic [7:0] op);
    logic [13:0] s;
    // no return from an empty stack: turn it into an illegal opcode
    if ((op == 8'hCD || op == 8'h4D) && stk.size() == 0)
      op ^= 8'h10;
    s = {flag_z_in, flag_c_in, pc + 12'h001};
    if (op == 8'hCD || op == 8'h4D) begin
      s = stk.pop_back();
      if (op[7])
        s[13:12] = {flag_z_in, flag_c_in};
    end
    run(op, 8'h00, 8'h00, 2, s[11:0], s[13:12]);
    chk("illegal", {11'h000, !ctl_known(op)}, {11'h000, saw});
    if (op == 8'h6D || op == 8'hED) begin
      chk("halt", {10'h000, (op[7] || wdog_opt_in) ? 2'b01 : 2'b10},
          {10'h000, stop_out, wait_out});
      repeat (3) @(negedge mclk_in);
      wake_in = 1'b1;
      wait_rd();
      wake_in = 1'b0;
    end
  endtask : ctl
  // corner cases, then a random program
  initial begin
    seed = $urandom(40);
    repeat (8) @(posedge mclk_in);
    @(negedge mclk_in);
    rst_in = 1'b0;
    wait_rd();
    pc = 12'h000;
    {flag_z_in, flag_c_in} = 2'b10;
    br(3'h4, 5'h10);
    {flag_z_in, flag_c_in} = 2'b01;
    br(3'h0, 5'h0F);
    bt(3'h7, 1'b1, 8'h80, 8'h80);
    bt(3'h0, 1'b0, 8'h7F, 8'hFE);
    jc(1'b0, 12'h5A0);
    {flag_z_in, flag_c_in} = 2'b10;
    ctl(8'h4D);
    for (int i = 0; i < 3; i++) begin
      wdog_opt_in = i[0];
      ctl(i[1] ? 8'hED : 8'h6D);
    end
    for (int i = 0; i < 300; i++) begin
      {flag_z_in, flag_c_in} = 2'($urandom);
      case ($urandom % 6)
        0: br({2'($urandom), 1'b0}, 5'($urandom));
        1: bt(3'($urandom), 1'($urandom), 8'($urandom), 8'($urandom));
        2: bm(3'($urandom), 1'($urandom));
        3: jc(stk.size() > 5 || 1'($urandom), 12'($urandom));
        4: ctl(stk.size() > 0 ? {1'($urandom), 7'h4D} : 8'h2D);
        default: ctl({5'($urandom), 1'b1, 1'($urandom), 1'b1});
      endcase
    end
    end_sim();
  end
  // watchdog against a hang
  initial begin
    repeat (6000) @(posedge mclk_in);
    fails++;
    end_sim();
  end
endmodule : tb_branch_bit_control_decoder
`default_nettype wire
